// file: ptbc_regs.sv
`timescale 1ns/1ps
`default_nettype none
module ptbc_regs #(
	parameter bit INSTANCE_B = 1'b0
) (
	input wire logic clk_sys_in,
	input wire logic srst_in,
	input wire ptbc_pkg::ptbc_host_req_s host_req_in,
	output logic [7:0] host_rdata_out,
	output logic host_ack_out,
	input wire logic [3:0][8:0] tx_fill_in,
	input wire logic [3:0][8:0] rx_fill_in,
	output logic [3:0] tx_full_out,
	output logic [3:0] rx_empty_out,
	output ptbc_pkg::ptbc_cal_cfg_s cal_cfg_out,
	output ptbc_pkg::ptbc_bank_cfg_s [3:0] bank_cfg_out,
	output logic [3:0] aggr_invalid_out,
	input wire logic status_run_in,
	input wire logic shadow_sel_in,
	output logic [10:0] cal_addr_out,
	output logic cal_valid_out,
	output logic frame_sync_out,
	input wire logic [7:0] core_stat_addr_in,
	output logic [1:0] core_stat_out
);
	// ***************************
	// address decode
	// ***************************
	logic [17:0] ofs_step;
	logic [17:0] a;
	logic [9:0] mem_page;
	logic [7:0] level_sel_reg;
	logic [7:0] main_rep_reg;
	logic [1:0] main_len_hi_reg;
	logic [7:0] main_len_lo_reg;
	logic [7:0] shd_rep_reg;
	logic [1:0] shd_len_hi_reg;
	logic [7:0] shd_len_lo_reg;
	logic [7:0] vfifo_reg;
	logic [7:0] aggr_reg;
	logic mem_sel_reg;
	logic mem_hit;
	logic mem_we;
	logic [7:0] reg_rdata_next;
	logic [7:0] reg_rdata_reg;
	logic mem_rd_reg;
	logic [1:0] mem_rdata;

	assign ofs_step = INSTANCE_B ? ptbc_pkg::OFS_B_STEP : 18'h00000;
	assign a = host_req_in.addr - ofs_step;
	assign mem_page = INSTANCE_B ? ptbc_pkg::STAT_MEM_PAGE + ptbc_pkg::STAT_MEM_PAGE_B_STEP
		: ptbc_pkg::STAT_MEM_PAGE;
	assign mem_hit = mem_sel_reg && (host_req_in.addr[17:8] == mem_page);
	assign mem_we = mem_hit && host_req_in.wr;

	// ***************************
	// register writes
	// ***************************
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			level_sel_reg <= ptbc_pkg::RST_LEVEL_SELECT;
			mem_sel_reg <= ptbc_pkg::RST_MEM_SELECT[0];
		end else if (host_req_in.wr && !mem_hit) begin
			if (a == ptbc_pkg::OFS_LEVEL_SELECT) begin
				level_sel_reg <= host_req_in.wdata;
			end else if (a == ptbc_pkg::OFS_MEM_SELECT) begin
				mem_sel_reg <= host_req_in.wdata[ptbc_pkg::STAT_MEM_SEL_BIT];
			end
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			main_rep_reg <= ptbc_pkg::RST_REPEAT;
			main_len_hi_reg <= ptbc_pkg::RST_LEN[1:0];
			main_len_lo_reg <= ptbc_pkg::RST_LEN;
			shd_rep_reg <= ptbc_pkg::RST_REPEAT;
			shd_len_hi_reg <= ptbc_pkg::RST_LEN[1:0];
			shd_len_lo_reg <= ptbc_pkg::RST_LEN;
		end else if (host_req_in.wr && !mem_hit) begin
			if (a == ptbc_pkg::OFS_MAIN_REPEAT) begin
				main_rep_reg <= host_req_in.wdata;
			end else if (a == ptbc_pkg::OFS_MAIN_LEN_HIGH) begin
				main_len_hi_reg <= host_req_in.wdata[1:0];
			end else if (a == ptbc_pkg::OFS_MAIN_LEN_LOW) begin
				main_len_lo_reg <= host_req_in.wdata;
			end else if (a == ptbc_pkg::OFS_SHD_REPEAT) begin
				shd_rep_reg <= host_req_in.wdata;
			end else if (a == ptbc_pkg::OFS_SHD_LEN_HIGH) begin
				shd_len_hi_reg <= host_req_in.wdata[1:0];
			end else if (a == ptbc_pkg::OFS_SHD_LEN_LOW) begin
				shd_len_lo_reg <= host_req_in.wdata;
			end
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			vfifo_reg <= ptbc_pkg::RST_VFIFO;
			aggr_reg <= ptbc_pkg::RST_AGGR;
		end else if (host_req_in.wr && !mem_hit) begin
			if (a == ptbc_pkg::OFS_VFIFO_COUNT) begin
				vfifo_reg <= host_req_in.wdata;
			end else if (a == ptbc_pkg::OFS_AGGR_WIDTH) begin
				aggr_reg <= host_req_in.wdata;
			end
		end
	end

	// ***************************
	// host read path
	// ***************************
	always_comb begin
		reg_rdata_next = 8'h00;
		if (a == ptbc_pkg::OFS_LEVEL_SELECT) begin
			reg_rdata_next = level_sel_reg;
		end else if (a == ptbc_pkg::OFS_MEM_SELECT) begin
			reg_rdata_next = {7'h00, mem_sel_reg};
		end else if (a == ptbc_pkg::OFS_MAIN_REPEAT) begin
			reg_rdata_next = main_rep_reg;
		end else if (a == ptbc_pkg::OFS_MAIN_LEN_HIGH) begin
			reg_rdata_next = {6'h00, main_len_hi_reg};
		end else if (a == ptbc_pkg::OFS_MAIN_LEN_LOW) begin
			reg_rdata_next = main_len_lo_reg;
		end else if (a == ptbc_pkg::OFS_SHD_REPEAT) begin
			reg_rdata_next = shd_rep_reg;
		end else if (a == ptbc_pkg::OFS_SHD_LEN_HIGH) begin
			reg_rdata_next = {6'h00, shd_len_hi_reg};
		end else if (a == ptbc_pkg::OFS_SHD_LEN_LOW) begin
			reg_rdata_next = shd_len_lo_reg;
		end else if (a == ptbc_pkg::OFS_VFIFO_COUNT) begin
			reg_rdata_next = vfifo_reg;
		end else if (a == ptbc_pkg::OFS_AGGR_WIDTH) begin
			reg_rdata_next = aggr_reg;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			reg_rdata_reg <= 8'h00;
			mem_rd_reg <= 1'b0;
			host_ack_out <= 1'b0;
		end else begin
			reg_rdata_reg <= reg_rdata_next;
			mem_rd_reg <= mem_hit;
			host_ack_out <= host_req_in.wr || host_req_in.rd;
		end
	end

	// upper six bits of each entry read as zero
	assign host_rdata_out = mem_rd_reg ? {6'h00, mem_rdata} : reg_rdata_reg;

	ptbc_stat_mem u_stat_mem (
		.clk_sys_in(clk_sys_in),
		.host_we_in(mem_we),
		.host_addr_in(host_req_in.addr[7:0]),
		.host_wdata_in(host_req_in.wdata[1:0]),
		.host_rdata_out(mem_rdata),
		.core_addr_in(core_stat_addr_in),
		.core_rdata_out(core_stat_out)
	);

	// ***************************
	// bank configuration
	// ***************************
	function automatic logic [3:0] vfifo_decode(input logic [1:0] code);
		vfifo_decode = 4'h1 << code;
	endfunction

	function automatic logic [8:0] part_lines(input logic [1:0] code);
		part_lines = ptbc_pkg::TX_BANK_LINES >> code;
	endfunction

	assign cal_cfg_out.main_len = {main_len_hi_reg, main_len_lo_reg};
	assign cal_cfg_out.main_repeat = main_rep_reg;
	assign cal_cfg_out.shd_len = {shd_len_hi_reg, shd_len_lo_reg};
	assign cal_cfg_out.shd_repeat = shd_rep_reg;

	// bank 0 sits in the top bit pair, bank 3 in the bottom
	always_comb begin
		for (int b = 0; b < ptbc_pkg::NUM_BANKS; b++) begin
			bank_cfg_out[b].vfifo_num = vfifo_decode(vfifo_reg[7 - 2 * b -: 2]);
			bank_cfg_out[b].aggr = ptbc_pkg::ptbc_aggr_e'(aggr_reg[7 - 2 * b -: 2]);
			aggr_invalid_out[b] = aggr_reg[7 - 2 * b -: 2] == ptbc_pkg::AGGR_INVALID;
		end
	end

	// ***************************
	// fill level detection
	// ***************************
	logic [3:0] tx_full_next;
	logic [3:0] rx_empty_next;
	logic [8:0] plines;
	logic [8:0] full_at;
	logic [8:0] empty_at;

	// levels are 128-bit lines, so aggregation width plays no part
	always_comb begin
		tx_full_next = 4'h0;
		rx_empty_next = 4'h0;
		plines = 9'h000;
		full_at = 9'h000;
		empty_at = 9'h000;
		for (int b = 0; b < ptbc_pkg::NUM_BANKS; b++) begin
			plines = part_lines(vfifo_reg[7 - 2 * b -: 2]);
			full_at = 9'((plines * 3) >> 2) + 9'h001;
			if (level_sel_reg[ptbc_pkg::FULL_SEL_LSB + 3 - b]) begin
				tx_full_next[b] = tx_fill_in[b] >= full_at;
			end else begin
				tx_full_next[b] = tx_fill_in[b] >= plines;
			end
			empty_at = (ptbc_pkg::RX_PART_LINES >> 2) - 9'h001;
			if (level_sel_reg[ptbc_pkg::EMPTY_SEL_LSB + 3 - b]) begin
				rx_empty_next[b] = rx_fill_in[b] <= empty_at;
			end else begin
				rx_empty_next[b] = rx_fill_in[b] == 9'h000;
			end
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			tx_full_out <= 4'h0;
			rx_empty_out <= 4'h0;
		end else begin
			tx_full_out <= tx_full_next;
			rx_empty_out <= rx_empty_next;
		end
	end

	// ***************************
	// status frame calendar walk
	// ***************************
	typedef enum logic [1:0] {
		PTBC_CAL_IDLE,
		PTBC_CAL_FRAME,
		PTBC_CAL_WALK
	} ptbc_cal_state_e;

	ptbc_cal_state_e cal_state_reg;
	logic use_shadow_reg;
	logic [9:0] entry_reg;
	logic [7:0] pass_reg;
	logic [9:0] cur_len;
	logic [7:0] cur_rep;
	logic last_entry;
	logic last_pass;

	assign cur_len = use_shadow_reg ? cal_cfg_out.shd_len : cal_cfg_out.main_len;
	assign cur_rep = use_shadow_reg ? shd_rep_reg : main_rep_reg;
	assign last_entry = (entry_reg + 10'h001) >= cur_len;
	// a repeat count of zero runs one pass
	assign last_pass = (pass_reg + 8'h01) >= cur_rep;

	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			cal_state_reg <= PTBC_CAL_IDLE;
			use_shadow_reg <= 1'b0;
			entry_reg <= 10'h000;
			pass_reg <= 8'h00;
		end else begin
			case (cal_state_reg)
				PTBC_CAL_IDLE: begin
					if (status_run_in) begin
						cal_state_reg <= PTBC_CAL_FRAME;
					end
				end
				PTBC_CAL_FRAME: begin
					// calendar choice changes only at a framing word
					use_shadow_reg <= shadow_sel_in;
					entry_reg <= 10'h000;
					pass_reg <= 8'h00;
					if (!status_run_in) begin
						cal_state_reg <= PTBC_CAL_IDLE;
					end else if ((shadow_sel_in ? cal_cfg_out.shd_len : cal_cfg_out.main_len)
						!= 10'h000) begin
						cal_state_reg <= PTBC_CAL_WALK;
					end
				end
				PTBC_CAL_WALK: begin
					if (!last_entry) begin
						entry_reg <= entry_reg + 10'h001;
					end else if (!last_pass) begin
						entry_reg <= 10'h000;
						pass_reg <= pass_reg + 8'h01;
					end else begin
						cal_state_reg <= PTBC_CAL_FRAME;
					end
				end
				default: begin
					cal_state_reg <= PTBC_CAL_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			cal_addr_out <= 11'h000;
			cal_valid_out <= 1'b0;
			frame_sync_out <= 1'b0;
		end else begin
			cal_addr_out <= (use_shadow_reg ? ptbc_pkg::SHADOW_CAL_BASE : 11'h000)
				+ {1'b0, entry_reg};
			cal_valid_out <= cal_state_reg == PTBC_CAL_WALK;
			frame_sync_out <= cal_state_reg == PTBC_CAL_FRAME;
		end
	end
endmodule
`default_nettype wire

// file: ptbc_pkg.sv
package ptbc_pkg;
	// host offsets, instance a; instance b adds the b step
	localparam logic [17:0] OFS_MEM_SELECT = 18'h30917;
	localparam logic [17:0] OFS_LEVEL_SELECT = 18'h30920;
	localparam logic [17:0] OFS_MAIN_REPEAT = 18'h30921;
	localparam logic [17:0] OFS_MAIN_LEN_HIGH = 18'h30922;
	localparam logic [17:0] OFS_MAIN_LEN_LOW = 18'h30923;
	localparam logic [17:0] OFS_SHD_REPEAT = 18'h30924;
	localparam logic [17:0] OFS_SHD_LEN_HIGH = 18'h30925;
	localparam logic [17:0] OFS_SHD_LEN_LOW = 18'h30926;
	localparam logic [17:0] OFS_VFIFO_COUNT = 18'h30927;
	localparam logic [17:0] OFS_AGGR_WIDTH = 18'h30930;
	localparam logic [17:0] OFS_B_STEP = 18'h00100;
	// status memory window, 256 bytes
	localparam logic [9:0] STAT_MEM_PAGE = 10'h300;
	localparam logic [9:0] STAT_MEM_PAGE_B_STEP = 10'h001;
	// field positions (vector bit = 7 - printed bit)
	localparam int STAT_MEM_SEL_BIT = 0;
	localparam int FULL_SEL_LSB = 4;
	localparam int EMPTY_SEL_LSB = 0;
	localparam logic [7:0] LEN_HIGH_MASK = 8'h03;
	localparam logic [7:0] MEM_SELECT_MASK = 8'h01;
	localparam logic [7:0] STAT_ENTRY_MASK = 8'h03;
	// reset values
	localparam logic [7:0] RST_LEVEL_SELECT = 8'h00;
	localparam logic [7:0] RST_REPEAT = 8'h00;
	localparam logic [7:0] RST_LEN = 8'h00;
	localparam logic [7:0] RST_VFIFO = 8'h00;
	localparam logic [7:0] RST_AGGR = 8'h00;
	localparam logic [7:0] RST_MEM_SELECT = 8'h00;
	// buffer geometry in 128-bit lines
	localparam int NUM_BANKS = 4;
	localparam logic [8:0] TX_BANK_LINES = 9'h100;
	localparam logic [8:0] RX_PART_LINES = 9'h020;
	// calendar memory split
	localparam logic [10:0] SHADOW_CAL_BASE = 11'h400;
	localparam logic [1:0] AGGR_INVALID = 2'h3;

	typedef enum logic [1:0] {
		PTBC_AGGR_32,
		PTBC_AGGR_64,
		PTBC_AGGR_128,
		PTBC_AGGR_BAD
	} ptbc_aggr_e;

	typedef struct packed {
		logic [17:0] addr;
		logic wr;
		logic rd;
		logic [7:0] wdata;
	} ptbc_host_req_s;

	typedef struct packed {
		logic [9:0] main_len;
		logic [7:0] main_repeat;
		logic [9:0] shd_len;
		logic [7:0] shd_repeat;
	} ptbc_cal_cfg_s;

	typedef struct packed {
		logic [3:0] vfifo_num;
		ptbc_aggr_e aggr;
	} ptbc_bank_cfg_s;
endpackage

// file: ptbc_stat_mem.sv
`timescale 1ns/1ps
`default_nettype none
module ptbc_stat_mem (
	input wire logic clk_sys_in,
	input wire logic host_we_in,
	input wire logic [7:0] host_addr_in,
	input wire logic [1:0] host_wdata_in,
	output logic [1:0] host_rdata_out,
	input wire logic [7:0] core_addr_in,
	output logic [1:0] core_rdata_out
);
	logic [1:0] mem [0:255];

	always_ff @(posedge clk_sys_in) begin
		if (host_we_in) begin
			mem[host_addr_in] <= host_wdata_in;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		host_rdata_out <= mem[host_addr_in];
		core_rdata_out <= mem[core_addr_in];
	end
endmodule
`default_nettype wire

// file: ptbc_regs_chk.sv
`timescale 1ns/1ps
`default_nettype none
// ****************
// host and level checks
// ****************
module ptbc_regs_chk #(
	parameter bit INSTANCE_B = 1'b0
) (
	input wire logic clk_sys_in,
	input wire logic srst_in,
	input wire ptbc_pkg::ptbc_host_req_s host_req_in,
	input wire logic [7:0] host_rdata_out,
	input wire logic host_ack_out,
	input wire logic [3:0][8:0] tx_fill_in,
	input wire logic [3:0][8:0] rx_fill_in,
	input wire logic [3:0] tx_full_out,
	input wire logic [3:0] rx_empty_out,
	input wire ptbc_pkg::ptbc_cal_cfg_s cal_cfg_out,
	input wire ptbc_pkg::ptbc_bank_cfg_s [3:0] bank_cfg_out,
	input wire logic [3:0] aggr_invalid_out,
	input wire logic cal_valid_out,
	input wire logic frame_sync_out
);
	logic [17:0] base;
	logic req;
	logic wr;
	assign base = INSTANCE_B ? ptbc_pkg::OFS_B_STEP : 18'h00000;
	assign req = host_req_in.wr | host_req_in.rd;
	assign wr = host_req_in.wr;
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (srst_in);
	chk_ack_follows: assert property (req |=> host_ack_out) else $error("ack missing");
	chk_ack_cause: assert property (host_ack_out |-> $past(req)) else $error("stray ack");
	chk_len_high: assert property (wr && host_req_in.addr == ptbc_pkg::OFS_MAIN_LEN_HIGH + base
		|=> cal_cfg_out.main_len[9:8] == $past(host_req_in.wdata[1:0])) else $error("len high");
	chk_shd_repeat: assert property (wr && host_req_in.addr == ptbc_pkg::OFS_SHD_REPEAT + base
		|=> cal_cfg_out.shd_repeat == $past(host_req_in.wdata)) else $error("shadow repeat");
	chk_vfifo_bank3: assert property (wr && host_req_in.addr == ptbc_pkg::OFS_VFIFO_COUNT + base
		|=> bank_cfg_out[3].vfifo_num == 4'h1 << $past(host_req_in.wdata[1:0])) else $error("vfifo");
	chk_unmapped_zero: assert property (host_req_in.rd && !wr && host_req_in.addr == 18'h30928 + base
		|=> host_rdata_out == 8'h00) else $error("unmapped read");
	chk_aggr_flag: assert property (aggr_invalid_out[0] == (bank_cfg_out[0].aggr == ptbc_pkg::PTBC_AGGR_BAD)) else $error("aggr flag");
	chk_frame_excl: assert property (!(frame_sync_out && cal_valid_out)) else $error("frame in slot");
	chk_rx_zero: assert property (rx_fill_in[0] == 9'h000 |=> rx_empty_out[0]) else $error("rx empty");
	chk_rx_above: assert property (rx_fill_in[0] > 9'h007 |=> !rx_empty_out[0]) else $error("rx not empty");
	chk_tx_top: assert property (tx_fill_in[0] >= 9'h100 |=> tx_full_out[0]) else $error("tx full");
	cov_frame: cover property (frame_sync_out);
	cov_full: cover property (tx_full_out[0]);
	cov_read: cover property (host_ack_out && host_rdata_out != 8'h00);
endmodule
bind ptbc_regs ptbc_regs_chk #(.INSTANCE_B(INSTANCE_B)) ptbc_regs_chk_i (
	.clk_sys_in(clk_sys_in),
	.srst_in(srst_in),
	.host_req_in(host_req_in),
	.host_rdata_out(host_rdata_out),
	.host_ack_out(host_ack_out),
	.tx_fill_in(tx_fill_in),
	.rx_fill_in(rx_fill_in),
	.tx_full_out(tx_full_out),
	.rx_empty_out(rx_empty_out),
	.cal_cfg_out(cal_cfg_out),
	.bank_cfg_out(bank_cfg_out),
	.aggr_invalid_out(aggr_invalid_out),
	.cal_valid_out(cal_valid_out),
	.frame_sync_out(frame_sync_out)
);
`default_nettype wire

// file: ptbc_link_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************
// far side buffer occupancy
// ****************
module ptbc_link_model (
	input wire logic clk_sys_in,
	input wire logic [3:0][8:0] tx_lvl_in,
	input wire logic [3:0][8:0] rx_lvl_in,
	output logic [3:0][8:0] tx_fill_out,
	output logic [3:0][8:0] rx_fill_out
);
	initial begin
		tx_fill_out = '0;
		rx_fill_out = '0;
	end
	// occupancy in 128-bit lines, reported one cycle late
	always @(posedge clk_sys_in) begin
		tx_fill_out <= tx_lvl_in;
		rx_fill_out <= rx_lvl_in;
	end
endmodule
`default_nettype wire

// file: testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
	// ****************
	// signals and instances
	// ****************
	logic clk_sys_in = 1'b0;
	logic srst_in = 1'b1;
	ptbc_pkg::ptbc_host_req_s req = '0;
	logic [7:0] rdata, got, a, d;
	logic ack, run = 1'b0, shd = 1'b0, cvalid, fsync;
	logic [3:0][8:0] tx_lvl = '0, rx_lvl = '0, tx_fill, rx_fill;
	logic [3:0] tx_full, rx_empty, aggr_bad;
	ptbc_pkg::ptbc_cal_cfg_s cal;
	ptbc_pkg::ptbc_bank_cfg_s [3:0] bank;
	logic [10:0] caddr;
	logic [7:0] saddr = '0;
	logic [1:0] sdata;
	logic [8:0] th;
	logic [7:0] wv [11];
	int error_cnt = 0, total_checks = 0, cycles = 0;
	localparam logic [17:0] REGS [11] = '{ptbc_pkg::OFS_MEM_SELECT, ptbc_pkg::OFS_LEVEL_SELECT,
		ptbc_pkg::OFS_MAIN_REPEAT, ptbc_pkg::OFS_MAIN_LEN_HIGH, ptbc_pkg::OFS_MAIN_LEN_LOW,
		ptbc_pkg::OFS_SHD_REPEAT, ptbc_pkg::OFS_SHD_LEN_HIGH, ptbc_pkg::OFS_SHD_LEN_LOW,
		ptbc_pkg::OFS_VFIFO_COUNT, ptbc_pkg::OFS_AGGR_WIDTH, 18'h30928};
	localparam logic [7:0] MSK [11] = '{8'h01, 8'hff, 8'hff, 8'h03, 8'hff, 8'hff, 8'h03, 8'hff,
		8'hff, 8'hff, 8'h00};
	ptbc_link_model ptbc_link_model_i (.clk_sys_in(clk_sys_in), .tx_lvl_in(tx_lvl),
		.rx_lvl_in(rx_lvl), .tx_fill_out(tx_fill), .rx_fill_out(rx_fill));
	ptbc_regs ptbc_regs_i (.clk_sys_in(clk_sys_in), .srst_in(srst_in), .host_req_in(req),
		.host_rdata_out(rdata), .host_ack_out(ack), .tx_fill_in(tx_fill), .rx_fill_in(rx_fill),
		.tx_full_out(tx_full), .rx_empty_out(rx_empty), .cal_cfg_out(cal), .bank_cfg_out(bank),
		.aggr_invalid_out(aggr_bad), .status_run_in(run), .shadow_sel_in(shd),
		.cal_addr_out(caddr), .cal_valid_out(cvalid), .frame_sync_out(fsync),
		.core_stat_addr_in(saddr), .core_stat_out(sdata));
	initial begin
		forever #5 clk_sys_in = ~clk_sys_in;
	end
	// ****************
	// tasks
	// ****************
	task automatic chk_sig(input logic [11:0] g, input logic [11:0] e);
		total_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("BAD %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic host(input logic w, input logic [17:0] ad, input logic [7:0] dt);
		req = '{addr: ad, wr: w, rd: !w, wdata: dt};
		@(posedge clk_sys_in);
		#1;
		req = '0;
		got = rdata;
		chk_sig(12'(ack), 12'h001);
		@(posedge clk_sys_in);
		#1;
	endtask
	task automatic rd_chk(input logic [17:0] ad, input logic [7:0] e);
		host(1'b0, ad, 8'h00);
		chk_sig(12'(got), 12'(e));
	endtask
	task automatic wait_frame;
		int n;
		n = 0;
		do begin
			@(posedge clk_sys_in);
			#1;
			n++;
		end while (fsync !== 1'b1 && n < 50);
		chk_sig(12'(fsync), 12'h001);
	endtask
	function automatic logic [8:0] full_thr(input logic [1:0] c, input logic s);
		logic [8:0] n;
		n = ptbc_pkg::TX_BANK_LINES >> c;
		return s ? (n >> 2) * 3 + 9'h001 : n;
	endfunction
	task automatic finish_test;
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	always @(posedge clk_sys_in) begin
		cycles++;
		if (cycles == 20000) begin
			error_cnt++;
			$display("BAD %0t timeout", $time);
			finish_test();
		end
	end
	// ****************
	// scenarios
	// ****************
	initial begin
		void'($urandom(32'h9ec5));
		repeat (2) @(posedge clk_sys_in);
		#1;
		srst_in = 1'b0;
		foreach (REGS[i]) rd_chk(REGS[i], 8'h00);
		foreach (REGS[i]) begin
			wv[i] = 8'($urandom) & (i == 9 ? 8'h66 : 8'hff);
			host(1'b1, REGS[i], wv[i]);
			rd_chk(REGS[i], wv[i] & MSK[i]);
		end
		chk_sig(12'(cal.main_len), {2'h0, wv[3][1:0], wv[4]});
		chk_sig(12'(cal.main_repeat), 12'(wv[2]));
		chk_sig(12'(cal.shd_len), {2'h0, wv[6][1:0], wv[7]});
		chk_sig(12'(cal.shd_repeat), 12'(wv[5]));
		for (int b = 0; b < 4; b++) begin
			chk_sig(12'(bank[b].vfifo_num), 12'h001 << ((wv[8] >> (6 - 2 * b)) & 8'h03));
			chk_sig(12'(bank[b].aggr), 12'((wv[9] >> (6 - 2 * b)) & 8'h03));
		end
		host(1'b1, ptbc_pkg::OFS_AGGR_WIDTH, 8'h96);
		chk_sig(12'(aggr_bad), 12'h000);
		chk_sig(12'(bank[0].aggr), 12'h002);
		for (int c = 0; c < 4; c++) begin
			for (int s = 0; s < 2; s++) begin
				host(1'b1, ptbc_pkg::OFS_VFIFO_COUNT, {4{2'(c)}});
				host(1'b1, ptbc_pkg::OFS_LEVEL_SELECT, s ? 8'hff : 8'h00);
				chk_sig(12'(bank[c].vfifo_num), 12'h001 << c);
				th = full_thr(2'(c), 1'(s));
				for (int k = 0; k < 2; k++) begin
					tx_lvl = {4{th - 9'(1 - k)}};
					rx_lvl = {4{9'(s * 7 + k)}};
					repeat (2) @(posedge clk_sys_in);
					#1;
					chk_sig(12'(tx_full), 12'(k ? 4'hf : 4'h0));
					chk_sig(12'(rx_empty), 12'(k ? 4'h0 : 4'hf));
				end
			end
		end
		host(1'b1, ptbc_pkg::OFS_MEM_SELECT, 8'h01);
		for (int k = 0; k < 8; k++) begin
			a = (k == 0) ? 8'h00 : (k == 1) ? 8'hff : 8'($urandom);
			d = 8'($urandom);
			host(1'b1, {ptbc_pkg::STAT_MEM_PAGE, a}, d);
			rd_chk({ptbc_pkg::STAT_MEM_PAGE, a}, d & 8'h03);
			saddr = a;
			@(posedge clk_sys_in);
			#1;
			chk_sig(12'(sdata), 12'(d[1:0]));
		end
		host(1'b1, ptbc_pkg::OFS_MEM_SELECT, 8'h00);
		rd_chk({ptbc_pkg::STAT_MEM_PAGE, a}, 8'h00);
		foreach (REGS[i]) host(1'b1, REGS[i], i inside {4} ? 8'h03 : i inside {7} ? 8'h02 :
			i inside {2} ? 8'h02 : i inside {5} ? 8'h03 : 8'h00);
		run = 1'b1;
		for (int s = 0; s < 2; s++) begin
			shd = 1'(s);
			wait_frame();
			wait_frame();
			for (int k = 0; k < 6; k++) begin
				@(posedge clk_sys_in);
				#1;
				chk_sig({cvalid, caddr}, {1'b1, 11'(s * 1024 + (s ? k % 2 : k % 3))});
			end
			@(posedge clk_sys_in);
			#1;
			chk_sig(12'(fsync), 12'h001);
		end
		finish_test();
	end
endmodule
`default_nettype wire
